/* File: rtl/liusi_cond_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "liusi_defs.svh"

// Carries raw alarm inputs to the synchroniser and clean levels and edges back.
interface liusi_cond_if;
  logic [`LIUSI_NCHAN*`LIUSI_SRC_W-1:0] raw;
  logic [`LIUSI_NCHAN*`LIUSI_SRC_W-1:0] level;
  logic [`LIUSI_NCHAN*`LIUSI_SRC_W-1:0] rise;
  logic [`LIUSI_NCHAN*`LIUSI_SRC_W-1:0] fall;

  modport sync (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface

`default_nettype wire

/* File: rtl/liusi_defs.svh */
`ifndef LIUSI_DEFS_SVH
`define LIUSI_DEFS_SVH

// Channel count and widths of the parallel port.
`define LIUSI_NCHAN        4
`define LIUSI_AW           5
`define LIUSI_SRC_W        24

// Register offsets inside one channel's address space.
`define LIUSI_OFF_SR       5'h06
`define LIUSI_OFF_IMR      5'h07
`define LIUSI_OFF_RECEIVE_INFO_REG_ONE     5'h08
`define LIUSI_OFF_RECEIVE_INFO_REG_TWO     5'h09
`define LIUSI_OFF_SUM_LO   5'h16
`define LIUSI_OFF_SUM_HI   5'h1F

// Event status bit positions.
`define LIUSI_BIT_LOOP_UP  7
`define LIUSI_BIT_TXCLK    5
`define LIUSI_BIT_UA1      4
`define LIUSI_BIT_CARRIER  3

// Latched positions per status register; the rest follow their source live.
`define LIUSI_SR_LATCHED   8'hD8
`define LIUSI_RECEIVE_INFO_REG_ONE_LATCHED 8'hFC
`define LIUSI_RECEIVE_INFO_REG_TWO_LATCHED 8'hFF

// Latched bits that stay set while their alarm is still present.
`define LIUSI_SR_HOLD      8'h18

// Sources that interrupt on both activation and deactivation.
`define LIUSI_SR_CHANGE    8'h38

// Assigned positions of the first receive information register.
`define LIUSI_RECEIVE_INFO_REG_ONE_USED    8'hFC

// Reset values.
`define LIUSI_IMR_RST      8'h00
`define LIUSI_STAT_RST     24'h000000
`define LIUSI_BYTE_RST     8'h00

`endif

/* File: rtl/liusi_pkg.sv */
`include "liusi_defs.svh"

package liusi_pkg;

  typedef logic [7:0] liusi_byte_t;

  // One-hot register select decoded from the port address.
  typedef enum logic [5:0] {
    LIUSI_SEL_NONE = 6'h01,
    LIUSI_SEL_SR   = 6'h02,
    LIUSI_SEL_IMR  = 6'h04,
    LIUSI_SEL_RECEIVE_INFO_REG_ONE = 6'h08,
    LIUSI_SEL_RECEIVE_INFO_REG_TWO = 6'h10,
    LIUSI_SEL_SUM  = 6'h20
  } liusi_sel_t;

  // Maps a channel-relative address onto the register it selects.
  function automatic liusi_sel_t liusi_decode(input logic [`LIUSI_AW-1:0] addr);
    liusi_sel_t sel;
    sel = LIUSI_SEL_NONE;
    if (addr == `LIUSI_OFF_SR) begin
      sel = LIUSI_SEL_SR;
    end else if (addr == `LIUSI_OFF_IMR) begin
      sel = LIUSI_SEL_IMR;
    end else if (addr == `LIUSI_OFF_RECEIVE_INFO_REG_ONE) begin
      sel = LIUSI_SEL_RECEIVE_INFO_REG_ONE;
    end else if (addr == `LIUSI_OFF_RECEIVE_INFO_REG_TWO) begin
      sel = LIUSI_SEL_RECEIVE_INFO_REG_TWO;
    end else if (addr >= `LIUSI_OFF_SUM_LO && addr <= `LIUSI_OFF_SUM_HI) begin
      sel = LIUSI_SEL_SUM;
    end
    return sel;
  endfunction

endpackage

/* File: rtl/liusi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "liusi_defs.svh"

module liusi_sync (
  input  wire logic     mclk_i,
  input  wire logic     rst_i,
  liusi_cond_if.sync    cif
);
  import liusi_pkg::*;

  localparam int W = `LIUSI_NCHAN*`LIUSI_SRC_W;

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] stab_reg;
  logic [W-1:0] stab_next;
  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;

  // Two-stage synchroniser followed by one history stage for edges.
  always_comb begin
    meta_next = cif.raw;
    stab_next = meta_reg;
    prev_next = stab_reg;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      stab_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      stab_reg <= stab_next;
      prev_reg <= prev_next;
    end
  end

  // Only the second stage and its history are looked at.
  assign cif.level = stab_reg;
  assign cif.rise  = stab_reg & ~prev_reg;
  assign cif.fall  = ~stab_reg & prev_reg;

endmodule

`default_nettype wire

/* File: rtl/liusi_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "liusi_defs.svh"

module liusi_top (
  input  wire logic                                  mclk_i,
  input  wire logic                                  rst_i,
  input  wire logic [1:0]                            chan_sel_i,
  input  wire logic [`LIUSI_AW-1:0]                  addr_i,
  input  wire logic                                  wr_i,
  input  wire logic                                  rd_i,
  input  wire liusi_pkg::liusi_byte_t                wdata_i,
  input  wire logic [`LIUSI_NCHAN*`LIUSI_SRC_W-1:0]  alarm_i,
  output logic      [7:0]                            rdata_o,
  output logic                                       int_n_o
);
  import liusi_pkg::*;

  liusi_cond_if cif ();

  liusi_sel_t  sel;
  logic [2:0]  stat_hit;
  logic [23:0] snap_w [`LIUSI_NCHAN];
  liusi_byte_t imr_w  [`LIUSI_NCHAN];
  logic [`LIUSI_NCHAN-1:0] irq_w;

  liusi_byte_t rdata_reg;
  liusi_byte_t rdata_next;
  logic        int_n_reg;
  logic        int_n_next;

  // Raw alarms enter the synchroniser before any status logic sees them.
  assign cif.raw = alarm_i;

  liusi_sync u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .cif    (cif)
  );

  // Address decode shared by every channel and by the read path.
  assign sel      = liusi_decode(addr_i);
  assign stat_hit = {sel == LIUSI_SEL_RECEIVE_INFO_REG_TWO, sel == LIUSI_SEL_RECEIVE_INFO_REG_ONE, sel == LIUSI_SEL_SR};

  for (genvar c = 0; c < `LIUSI_NCHAN; c++) begin : g_chan
    logic [23:0] lat_reg;
    logic [23:0] lat_next;
    logic [23:0] snap_reg;
    logic [23:0] snap_next;
    logic [23:0] msk_reg;
    logic [23:0] msk_next;
    liusi_byte_t imr_reg;
    liusi_byte_t imr_next;
    liusi_byte_t ip_reg;
    liusi_byte_t ip_next;
    logic [23:0] lvl;
    logic [23:0] rise;
    logic [23:0] fall;
    logic [23:0] latm;
    logic [23:0] hold;
    logic [23:0] live;
    logic [23:0] set;
    logic [23:0] clr;
    liusi_byte_t ip_set;
    liusi_byte_t ip_clr;
    logic        wr_c;
    logic        rd_c;

    assign lvl  = cif.level[c*`LIUSI_SRC_W +: `LIUSI_SRC_W];
    assign rise = cif.rise[c*`LIUSI_SRC_W +: `LIUSI_SRC_W];
    assign fall = cif.fall[c*`LIUSI_SRC_W +: `LIUSI_SRC_W];
    assign wr_c = wr_i && (chan_sel_i == 2'(c));
    assign rd_c = rd_i && (chan_sel_i == 2'(c));
    assign latm = {`LIUSI_RECEIVE_INFO_REG_TWO_LATCHED, `LIUSI_RECEIVE_INFO_REG_ONE_LATCHED, `LIUSI_SR_LATCHED};
    assign hold = {16'h0000, `LIUSI_SR_HOLD};

    // Latched bits catch rising edges; hold bits are also set while their level is high.
    assign set  = (latm & rise) | (hold & lvl);
    // Latest information: latch for latched bits, synced level for live ones.
    assign live = (latm & lat_reg) | (~latm & lvl);

    // Status latches, snapshots, masks and interrupt pending bits.
    always_comb begin
      lat_next  = lat_reg;
      snap_next = snap_reg;
      msk_next  = msk_reg;
      imr_next  = imr_reg;
      clr       = 24'h000000;
      for (int r = 0; r < 3; r++) begin
        // A read clears only the bits that were in the mask and read as 1.
        if (rd_c && stat_hit[r]) begin
          clr[r*8 +: 8] = msk_reg[r*8 +: 8] & snap_reg[r*8 +: 8];
        end
        // Mask write refreshes chosen positions and holds the others.
        if (wr_c && stat_hit[r]) begin
          snap_next[r*8 +: 8] = (wdata_i & live[r*8 +: 8]) |
                                (~wdata_i & snap_reg[r*8 +: 8]);
          msk_next[r*8 +: 8]  = wdata_i;
        end
      end
      // A new event in the clearing cycle wins over the clear.
      lat_next = ((lat_reg & ~clr) | set) & latm;
      if (wr_c && sel == LIUSI_SEL_IMR) begin
        imr_next = wdata_i;
      end
      // Change sources interrupt on both edges, others on setting.
      ip_set  = rise[7:0] | (`LIUSI_SR_CHANGE & fall[7:0]);
      // Reading a bit of the event status register releases its interrupt.
      ip_clr  = (rd_c && stat_hit[0]) ? msk_reg[7:0] : `LIUSI_BYTE_RST;
      ip_next = (ip_reg & ~ip_clr) | ip_set;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        lat_reg  <= `LIUSI_STAT_RST;
        snap_reg <= `LIUSI_STAT_RST;
        msk_reg  <= `LIUSI_STAT_RST;
        imr_reg  <= `LIUSI_IMR_RST;
        ip_reg   <= `LIUSI_BYTE_RST;
      end else begin
        lat_reg  <= lat_next;
        snap_reg <= snap_next;
        msk_reg  <= msk_next;
        imr_reg  <= imr_next;
        ip_reg   <= ip_next;
      end
    end

    // Only event status sources reach the interrupt, each through its mask.
    assign irq_w[c]  = |(ip_reg & imr_reg);
    assign snap_w[c] = snap_reg;
    assign imr_w[c]  = imr_reg;
  end

  // Read data and the shared interrupt pin.
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_i) begin
      unique case (sel)
        LIUSI_SEL_SR:   rdata_next = snap_w[chan_sel_i][7:0];
        LIUSI_SEL_IMR:  rdata_next = imr_w[chan_sel_i];
        LIUSI_SEL_RECEIVE_INFO_REG_ONE: rdata_next = snap_w[chan_sel_i][15:8] & `LIUSI_RECEIVE_INFO_REG_ONE_USED;
        LIUSI_SEL_RECEIVE_INFO_REG_TWO: rdata_next = snap_w[chan_sel_i][23:16];
        LIUSI_SEL_SUM:  rdata_next = {4'h0, irq_w};
        LIUSI_SEL_NONE: rdata_next = `LIUSI_BYTE_RST;
        default:        rdata_next = `LIUSI_BYTE_RST;
      endcase
    end
    int_n_next = ~(|irq_w);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= `LIUSI_BYTE_RST;
      int_n_reg <= 1'b1;
    end else begin
      rdata_reg <= rdata_next;
      int_n_reg <= int_n_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign int_n_o = int_n_reg;

endmodule

`default_nettype wire

/* File: sim/liusi_alarm_src.sv */
`timescale 1ns/1ps
`default_nettype none

module liusi_alarm_src (
  input  wire logic [95:0] want_i,
  output var logic  [95:0] alarm_o
);
  // Alarms follow the bench a few nanoseconds late, off the clock edge, from time zero on.
  assign #7 alarm_o = want_i;
endmodule

`default_nettype wire

/* File: sim/liusi_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "liusi_defs.svh"

module liusi_top_monitor (
  input wire logic                                 mclk_i,
  input wire logic                                 rst_i,
  input wire logic [1:0]                           chan_sel_i,
  input wire logic [`LIUSI_AW-1:0]                 addr_i,
  input wire logic                                 wr_i,
  input wire logic                                 rd_i,
  input wire liusi_pkg::liusi_byte_t               wdata_i,
  input wire logic [`LIUSI_NCHAN*`LIUSI_SRC_W-1:0] alarm_i,
  input wire logic [7:0]                           rdata_o,
  input wire logic                                 int_n_o
);
  import liusi_pkg::*;

  // All checks share the register clock and drop out during reset.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_int_after_reset: assert property ($past(rst_i) |-> int_n_o)
    else $error("interrupt low right after reset");
  a_unmapped_zero: assert property (rd_i && addr_i < 5'h16 &&
    !(addr_i inside {5'h06, 5'h07, 5'h08, 5'h09}) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_sum_high_zero: assert property (rd_i && addr_i >= 5'h16 |=> rdata_o[7:4] == 4'h0)
    else $error("summary upper bits not zero");
  a_sum_int_match: assert property (rd_i && addr_i >= 5'h16 |=>
    (rdata_o[3:0] != 4'h0) == !int_n_o)
    else $error("summary disagrees with interrupt");
  a_rx_low_zero: assert property (rd_i && addr_i == 5'h08 |=> rdata_o[1:0] == 2'h0)
    else $error("unassigned receive bits not zero");
  a_int_hold_low: assert property (!rd_i && !wr_i ##1 !int_n_o |=> !int_n_o)
    else $error("interrupt released without access");
  a_int_release_cause: assert property ($rose(int_n_o) |-> $past(rd_i, 2) || $past(wr_i, 2))
    else $error("interrupt released without read");
endmodule

bind liusi_top liusi_top_monitor u_mon (.mclk_i, .rst_i, .chan_sel_i, .addr_i, .wr_i,
  .rd_i, .wdata_i, .alarm_i, .rdata_o, .int_n_o);

`default_nettype wire

/* File: sim/liusi_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module liusi_top_test;
  import liusi_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  chan_sel_i = 2'h0;
  logic [4:0]  addr_i = 5'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  liusi_byte_t wdata_i = 8'h00;
  logic [95:0] want = '0;
  logic [95:0] alarm;
  logic [7:0]  rdata_o;
  logic        int_n_o;
  int          n_fail = 0;
  int          checks = 0;

  liusi_alarm_src SRC (.want_i(want), .alarm_o(alarm));
  liusi_top DUT (.mclk_i, .rst_i, .chan_sel_i, .addr_i, .wr_i, .rd_i, .wdata_i,
    .alarm_i(alarm), .rdata_o, .int_n_o);

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 mclk_i = ~mclk_i;

  task automatic close_out;
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [1:0] c, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    chan_sel_i <= c; addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // Read data lands one cycle after the strobe, so it is taken at the falling edge.
  task automatic rd(input logic [1:0] c, input logic [4:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    chan_sel_i <= c; addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    `CK("read", e, rdata_o)
  endtask

  // Mask write, read, then write back the read value ANDed with the mask.
  task automatic poll(input logic [1:0] c, input logic [4:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] q;
    wr(c, a, m);
    rd(c, a, e);
    q = rdata_o;
    wr(c, a, q & m);
  endtask

  // Moves one alarm source and lets it pass the synchroniser.
  task automatic al(input int i, input logic v);
    @(posedge mclk_i);
    want[i] <= v;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  // The pin is registered, so it follows a mask or pending change one edge later.
  task automatic ck_int(input logic e);
    @(posedge mclk_i);
    @(negedge mclk_i);
    `CK("int_n", e, int_n_o)
  endtask

  // Cuts a hang short well beyond the length of the sequence.
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(0, 5'h07, 8'h00);
    rd(0, 5'h0A, 8'h00);
    wr(0, 5'h16, 8'hFF);
    rd(0, 5'h1F, 8'h00);
    al(31, 1'b1);
    al(30, 1'b1);
    ck_int(1'b1);
    wr(1, 5'h07, 8'h80);
    ck_int(1'b0);
    rd(0, 5'h1F, 8'h02);
    poll(1, 5'h06, 8'h80, 8'h80);
    ck_int(1'b1);
    poll(1, 5'h06, 8'h40, 8'h40);
    poll(1, 5'h06, 8'h80, 8'h00);
    wr(3, 5'h07, 8'h08);
    al(75, 1'b1);
    ck_int(1'b0);
    rd(2, 5'h16, 8'h08);
    poll(3, 5'h06, 8'h08, 8'h08);
    ck_int(1'b1);
    poll(3, 5'h06, 8'h08, 8'h08);
    al(75, 1'b0);
    ck_int(1'b0);
    poll(3, 5'h06, 8'h08, 8'h08);
    ck_int(1'b1);
    al(5, 1'b1);
    poll(0, 5'h06, 8'h20, 8'h20);
    ck_int(1'b1);
    al(5, 1'b0);
    poll(0, 5'h06, 8'h20, 8'h00);
    al(15, 1'b1);
    al(15, 1'b0);
    poll(0, 5'h08, 8'hFF, 8'h80);
    poll(0, 5'h08, 8'hFF, 8'h00);
    al(16, 1'b1);
    poll(0, 5'h09, 8'h01, 8'h01);
    close_out();
  end
endmodule

`default_nettype wire
